// [common/mmr_regs.svh]
// Register offsets, field positions, reset values and ranges of the meter register bank.
// Assumes a 16-bit register address and 16-bit two's complement data.
`ifndef MMR_REGS_SVH
`define MMR_REGS_SVH

`define MMR_OFF_MEAS 8'h01
`define MMR_OFF_COND 8'h02
`define MMR_OFF_DP 8'h03
`define MMR_OFF_OUTS 8'h04
`define MMR_OFF_PEAK 8'h06
`define MMR_OFF_SPAN 8'h10
`define MMR_OFF_CURVE 8'h11
`define MMR_OFF_SMOOTH 8'h12
`define MMR_OFF_DP_MIR 8'h13
`define MMR_OFF_SC_BOT 8'h14
`define MMR_OFF_SC_TOP 8'h15
`define MMR_OFF_UTOL 8'h16
`define MMR_OFF_OTOL 8'h17
`define MMR_OFF_NODE 8'h20
`define MMR_OFF_IDENT 8'h21
`define MMR_OFF_RATE 8'h22
`define MMR_OFF_PERMIT 8'h23
`define MMR_OFF_LOCKS 8'h24
`define MMR_OFF_WAIT 8'h25
`define MMR_OFF_SILENCE 8'h27
`define MMR_OFF_BRIGHT 8'h2D
`define MMR_OFF_ENTRY 8'h2F

`define MMR_BIT_RELAY1 0
`define MMR_BIT_RELAY2 1
`define MMR_BIT_ALARM 4

`define MMR_COND_VALID 16'h0000
`define MMR_COND_OVER 16'h00A0
`define MMR_COND_UNDER 16'h0060

`define MMR_VAL_MIN 16'hFC19
`define MMR_VAL_MAX 16'h270F
`define MMR_UTOL_MAX 16'h03E7
`define MMR_OTOL_MAX 16'h00C7
`define MMR_NODE_MAX 16'h00C7
`define MMR_DP_MAX 16'h0003
`define MMR_SPAN_MAX 16'h0005
`define MMR_CURVE_MAX 16'h0003
`define MMR_SMOOTH_MAX 16'h0005
`define MMR_RATE_MAX 16'h0007
`define MMR_PERMIT_MAX 16'h0001
`define MMR_LOCKS_MAX 16'h000F
`define MMR_WAIT_MAX 16'h0005
`define MMR_SILENCE_MAX 16'h0063
`define MMR_BRIGHT_MIN 16'h0001
`define MMR_BRIGHT_MAX 16'h0008
`define MMR_ENTRY_MAX 16'h0001

`define MMR_RST_DP 2'h0
`define MMR_RST_SPAN 3'h1
`define MMR_RST_CURVE 2'h0
`define MMR_RST_SMOOTH 3'h0
`define MMR_RST_SC_BOT 16'h0000
`define MMR_RST_SC_TOP 16'h03E8
`define MMR_RST_UTOL 10'h000
`define MMR_RST_OTOL 8'h00
`define MMR_RST_NODE 8'h01
`define MMR_RST_RATE 3'h3
`define MMR_RST_PERMIT 1'h1
`define MMR_RST_LOCKS 4'h0
`define MMR_RST_WAIT 3'h0
`define MMR_RST_SILENCE 7'h00
`define MMR_RST_BRIGHT 4'h8
`define MMR_RST_ENTRY 1'h0

`define MMR_EXC_NONE 8'h00
`define MMR_EXC_ADDR 8'h02
`define MMR_EXC_DATA 8'h03
`define MMR_EXC_PERM 8'h08

`endif

// [common/mmr_pkg.sv]
// Types of the meter register bank.
// Offsets and constants live in mmr_regs.svh.
package mmr_pkg;
	typedef enum logic [2:0] {
		MMR_SPAN_0_20MA,
		MMR_SPAN_4_20MA,
		MMR_SPAN_0_10V,
		MMR_SPAN_2_10V,
		MMR_SPAN_0_5V,
		MMR_SPAN_1_5V,
		MMR_SPAN_BAD6,
		MMR_SPAN_BAD7
	} mmr_span_e;
	typedef enum logic [1:0] {
		MMR_CURVE_LINEAR,
		MMR_CURVE_SQUARE,
		MMR_CURVE_ROOT,
		MMR_CURVE_USER
	} mmr_curve_e;
	typedef enum logic [1:0] {
		MMR_ST_IDLE,
		MMR_ST_READ,
		MMR_ST_WRITE
	} mmr_state_e;
endpackage

// [src/mmr_range_check.sv]
// Range checker for values written into the register bank.
// Purely combinational; the bank registers its result.
`timescale 1ns/10ps
`include "mmr_regs.svh"
module mmr_range_check (
	// Target register and candidate value
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	// Verdict
	output logic writable,
	output logic in_range
);
	function automatic logic le_u(input logic [15:0] v, input logic [15:0] hi);
		le_u = (v <= hi);
	endfunction

	function automatic logic in_signed(input logic [15:0] v);
		in_signed = ($signed(v) >= $signed(`MMR_VAL_MIN)) && ($signed(v) <= $signed(`MMR_VAL_MAX));
	endfunction

	always_comb begin
		writable = 1'b1;
		in_range = 1'b0;
		case (addr)
			`MMR_OFF_DP, `MMR_OFF_DP_MIR: in_range = le_u(wdata, `MMR_DP_MAX);
			`MMR_OFF_OUTS: in_range = 1'b1;
			`MMR_OFF_SPAN: in_range = le_u(wdata, `MMR_SPAN_MAX);
			`MMR_OFF_CURVE: in_range = le_u(wdata, `MMR_CURVE_MAX);
			`MMR_OFF_SMOOTH: in_range = le_u(wdata, `MMR_SMOOTH_MAX);
			`MMR_OFF_SC_BOT, `MMR_OFF_SC_TOP: in_range = in_signed(wdata);
			`MMR_OFF_UTOL: in_range = le_u(wdata, `MMR_UTOL_MAX);
			`MMR_OFF_OTOL: in_range = le_u(wdata, `MMR_OTOL_MAX);
			`MMR_OFF_NODE: in_range = le_u(wdata, `MMR_NODE_MAX);
			`MMR_OFF_RATE: in_range = le_u(wdata, `MMR_RATE_MAX);
			`MMR_OFF_PERMIT: in_range = le_u(wdata, `MMR_PERMIT_MAX);
			`MMR_OFF_LOCKS: in_range = le_u(wdata, `MMR_LOCKS_MAX);
			`MMR_OFF_WAIT: in_range = le_u(wdata, `MMR_WAIT_MAX);
			`MMR_OFF_SILENCE: in_range = le_u(wdata, `MMR_SILENCE_MAX);
			`MMR_OFF_BRIGHT: in_range = (wdata >= `MMR_BRIGHT_MIN) && le_u(wdata, `MMR_BRIGHT_MAX);
			`MMR_OFF_ENTRY: in_range = le_u(wdata, `MMR_ENTRY_MAX);
			default: writable = 1'b0;
		endcase
	end
endmodule

// [src/mmr_bank.sv]
// Holding-register bank of a panel meter, reached by the serial protocol engine.
// Assumes the engine decodes frames and presents one register access at a time,
// on the same clock; the measurement path feeds value, condition and extreme.
`timescale 1ns/10ps
`include "mmr_regs.svh"
module mmr_bank #(
	parameter logic [15:0] IDENT_CODE = 16'h5A5A // Arbitrary value
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Access from the protocol engine
	input wire logic acc_valid,
	input wire logic [7:0] acc_func,
	input wire logic [15:0] acc_addr,
	input wire logic [15:0] acc_wdata,
	output logic acc_done,
	output logic [15:0] acc_rdata,
	output logic [7:0] acc_exc,
	// Local front-panel permit restore
	input wire logic local_permit_set,
	// Measurement path, same clock
	input wire logic [15:0] meas_value,
	input wire logic meas_over,
	input wire logic meas_under,
	input wire logic [15:0] extreme_value,
	input wire logic alarm_led,
	// Settings to the rest of the meter
	output logic first_relay,
	output logic second_relay,
	output logic [1:0] decimal_position,
	output mmr_pkg::mmr_span_e input_span,
	output mmr_pkg::mmr_curve_e curve,
	output logic [2:0] smoothing_rate,
	output logic [15:0] scale_bottom,
	output logic [15:0] scale_top,
	output logic [9:0] under_tolerance,
	output logic [7:0] over_tolerance,
	output logic [7:0] node_address,
	output logic [2:0] line_rate,
	output logic remote_write_permit,
	output logic [3:0] menu_lock_flags,
	output logic [2:0] reply_extra_wait,
	output logic [6:0] link_silence_limit,
	output logic [3:0] display_intensity,
	output logic glide_entry
);
	localparam logic [7:0] FN_READ = 8'h03;
	localparam logic [7:0] FN_WR1 = 8'h06;
	localparam logic [7:0] FN_WRN = 8'h10;
	localparam logic [7:0] EXC_FUNC = 8'h01;

	logic [1:0] dp_r, dp_nxt;
	mmr_pkg::mmr_span_e span_r, span_nxt;
	mmr_pkg::mmr_curve_e curve_r, curve_nxt;
	logic [2:0] smooth_r, smooth_nxt;
	logic [15:0] bot_r, bot_nxt;
	logic [15:0] top_r, top_nxt;
	logic [9:0] utol_r, utol_nxt;
	logic [7:0] otol_r, otol_nxt;
	logic [7:0] node_r, node_nxt;
	logic [2:0] rate_r, rate_nxt;
	logic permit_r, permit_nxt;
	logic [3:0] locks_r, locks_nxt;
	logic [2:0] wait_r, wait_nxt;
	logic [6:0] silence_r, silence_nxt;
	logic [3:0] bright_r, bright_nxt;
	logic entry_r, entry_nxt;
	logic relay1_r, relay1_nxt;
	logic relay2_r, relay2_nxt;
	logic done_r, done_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic [7:0] exc_r, exc_nxt;

	logic writable;
	logic in_range;
	logic [15:0] rd_word;
	logic rd_ok;
	logic is_write;
	logic wr_go;

	mmr_range_check u_check (
		.addr(acc_addr[7:0]),
		.wdata(acc_wdata),
		.writable(writable),
		.in_range(in_range)
	);

	// Read multiplexer; unmapped offsets flag an address exception
	always_comb begin
		rd_ok = (acc_addr[15:8] == 8'h00);
		rd_word = 16'h0000;
		case (acc_addr[7:0])
			`MMR_OFF_MEAS: rd_word = meas_value;
			`MMR_OFF_COND: begin
				if (meas_over) begin
					rd_word = `MMR_COND_OVER;
				end else if (meas_under) begin
					rd_word = `MMR_COND_UNDER;
				end else begin
					rd_word = `MMR_COND_VALID;
				end
			end
			`MMR_OFF_DP, `MMR_OFF_DP_MIR: rd_word = {14'h0000, dp_r};
			`MMR_OFF_OUTS: begin
				rd_word = 16'h0000;
				rd_word[`MMR_BIT_RELAY1] = relay1_r;
				rd_word[`MMR_BIT_RELAY2] = relay2_r;
				rd_word[`MMR_BIT_ALARM] = alarm_led;
			end
			`MMR_OFF_PEAK: rd_word = extreme_value;
			`MMR_OFF_SPAN: rd_word = {13'h0000, span_r};
			`MMR_OFF_CURVE: rd_word = {14'h0000, curve_r};
			`MMR_OFF_SMOOTH: rd_word = {13'h0000, smooth_r};
			`MMR_OFF_SC_BOT: rd_word = bot_r;
			`MMR_OFF_SC_TOP: rd_word = top_r;
			`MMR_OFF_UTOL: rd_word = {6'h00, utol_r};
			`MMR_OFF_OTOL: rd_word = {8'h00, otol_r};
			`MMR_OFF_NODE: rd_word = {8'h00, node_r};
			`MMR_OFF_IDENT: rd_word = IDENT_CODE;
			`MMR_OFF_RATE: rd_word = {13'h0000, rate_r};
			`MMR_OFF_PERMIT: rd_word = {15'h0000, permit_r};
			`MMR_OFF_LOCKS: rd_word = {12'h000, locks_r};
			`MMR_OFF_WAIT: rd_word = {13'h0000, wait_r};
			`MMR_OFF_SILENCE: rd_word = {9'h000, silence_r};
			`MMR_OFF_BRIGHT: rd_word = {12'h000, bright_r};
			`MMR_OFF_ENTRY: rd_word = {15'h0000, entry_r};
			default: rd_ok = 1'b0;
		endcase
	end

	// Access decode: function, address, permission, range, in that priority
	always_comb begin
		done_nxt = acc_valid;
		rdata_nxt = 16'h0000;
		exc_nxt = `MMR_EXC_NONE;
		is_write = (acc_func == FN_WR1) || (acc_func == FN_WRN);
		wr_go = 1'b0;
		if (acc_valid) begin
			if ((acc_func != FN_READ) && !is_write) begin
				exc_nxt = EXC_FUNC;
			end else if (!rd_ok) begin
				exc_nxt = `MMR_EXC_ADDR;
			end else if (!is_write) begin
				rdata_nxt = rd_word;
			end else if (!permit_r) begin
				exc_nxt = `MMR_EXC_PERM;
			end else if (!writable || !in_range) begin
				exc_nxt = `MMR_EXC_DATA;
			end else if ((acc_addr[7:0] == `MMR_OFF_PERMIT) && acc_wdata[0]) begin
				// Permit may only be restored from the front panel
				exc_nxt = `MMR_EXC_DATA;
			end else begin
				wr_go = 1'b1;
			end
		end
	end

	// Next values of the setting registers
	always_comb begin
		dp_nxt = dp_r;
		span_nxt = span_r;
		curve_nxt = curve_r;
		smooth_nxt = smooth_r;
		bot_nxt = bot_r;
		top_nxt = top_r;
		utol_nxt = utol_r;
		otol_nxt = otol_r;
		node_nxt = node_r;
		rate_nxt = rate_r;
		permit_nxt = permit_r;
		locks_nxt = locks_r;
		wait_nxt = wait_r;
		silence_nxt = silence_r;
		bright_nxt = bright_r;
		entry_nxt = entry_r;
		relay1_nxt = relay1_r;
		relay2_nxt = relay2_r;
		if (wr_go) begin
			case (acc_addr[7:0])
				`MMR_OFF_DP, `MMR_OFF_DP_MIR: dp_nxt = acc_wdata[1:0];
				`MMR_OFF_OUTS: begin
					relay1_nxt = acc_wdata[`MMR_BIT_RELAY1];
					relay2_nxt = acc_wdata[`MMR_BIT_RELAY2];
				end
				`MMR_OFF_SPAN: span_nxt = mmr_pkg::mmr_span_e'(acc_wdata[2:0]);
				`MMR_OFF_CURVE: curve_nxt = mmr_pkg::mmr_curve_e'(acc_wdata[1:0]);
				`MMR_OFF_SMOOTH: smooth_nxt = acc_wdata[2:0];
				`MMR_OFF_SC_BOT: bot_nxt = acc_wdata;
				`MMR_OFF_SC_TOP: top_nxt = acc_wdata;
				`MMR_OFF_UTOL: utol_nxt = acc_wdata[9:0];
				`MMR_OFF_OTOL: otol_nxt = acc_wdata[7:0];
				`MMR_OFF_NODE: node_nxt = acc_wdata[7:0];
				`MMR_OFF_RATE: rate_nxt = acc_wdata[2:0];
				`MMR_OFF_PERMIT: permit_nxt = 1'b0;
				`MMR_OFF_LOCKS: locks_nxt = acc_wdata[3:0];
				`MMR_OFF_WAIT: wait_nxt = acc_wdata[2:0];
				`MMR_OFF_SILENCE: silence_nxt = acc_wdata[6:0];
				`MMR_OFF_BRIGHT: bright_nxt = acc_wdata[3:0];
				`MMR_OFF_ENTRY: entry_nxt = acc_wdata[0];
				default: dp_nxt = dp_r;
			endcase
		end
		// Front panel wins over a remote clear in the same cycle
		if (local_permit_set) begin
			permit_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dp_r <= `MMR_RST_DP;
			span_r <= mmr_pkg::mmr_span_e'(`MMR_RST_SPAN);
			curve_r <= mmr_pkg::mmr_curve_e'(`MMR_RST_CURVE);
			smooth_r <= `MMR_RST_SMOOTH;
			bot_r <= `MMR_RST_SC_BOT;
			top_r <= `MMR_RST_SC_TOP;
			utol_r <= `MMR_RST_UTOL;
			otol_r <= `MMR_RST_OTOL;
			node_r <= `MMR_RST_NODE;
			rate_r <= `MMR_RST_RATE;
			permit_r <= `MMR_RST_PERMIT;
			locks_r <= `MMR_RST_LOCKS;
			wait_r <= `MMR_RST_WAIT;
			silence_r <= `MMR_RST_SILENCE;
			bright_r <= `MMR_RST_BRIGHT;
			entry_r <= `MMR_RST_ENTRY;
			relay1_r <= 1'b0;
			relay2_r <= 1'b0;
			done_r <= 1'b0;
			rdata_r <= 16'h0000;
			exc_r <= `MMR_EXC_NONE;
		end else begin
			dp_r <= dp_nxt;
			span_r <= span_nxt;
			curve_r <= curve_nxt;
			smooth_r <= smooth_nxt;
			bot_r <= bot_nxt;
			top_r <= top_nxt;
			utol_r <= utol_nxt;
			otol_r <= otol_nxt;
			node_r <= node_nxt;
			rate_r <= rate_nxt;
			permit_r <= permit_nxt;
			locks_r <= locks_nxt;
			wait_r <= wait_nxt;
			silence_r <= silence_nxt;
			bright_r <= bright_nxt;
			entry_r <= entry_nxt;
			relay1_r <= relay1_nxt;
			relay2_r <= relay2_nxt;
			done_r <= done_nxt;
			rdata_r <= rdata_nxt;
			exc_r <= exc_nxt;
		end
	end

	assign acc_done = done_r;
	assign acc_rdata = rdata_r;
	assign acc_exc = exc_r;
	assign first_relay = relay1_r;
	assign second_relay = relay2_r;
	assign decimal_position = dp_r;
	assign input_span = span_r;
	assign curve = curve_r;
	assign smoothing_rate = smooth_r;
	assign scale_bottom = bot_r;
	assign scale_top = top_r;
	assign under_tolerance = utol_r;
	assign over_tolerance = otol_r;
	assign node_address = node_r;
	assign line_rate = rate_r;
	assign remote_write_permit = permit_r;
	assign menu_lock_flags = locks_r;
	assign reply_extra_wait = wait_r;
	assign link_silence_limit = silence_r;
	assign display_intensity = bright_r;
	assign glide_entry = entry_r;
endmodule

// [test/mmr_bank_properties.sv]
// Checker for the meter register bank, bound to every mmr_bank instance.
// Assumes one access per request, answered exactly one cycle later.
`timescale 1ns/10ps
module mmr_bank_properties #(
	parameter logic [15:0] IDENT_CODE = 16'h5A5A
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Access
	input wire logic acc_valid,
	input wire logic [7:0] acc_func,
	input wire logic [15:0] acc_addr,
	input wire logic [15:0] acc_wdata,
	input wire logic acc_done,
	input wire logic [15:0] acc_rdata,
	input wire logic [7:0] acc_exc,
	// Local and measurement inputs
	input wire logic local_permit_set,
	input wire logic [15:0] meas_value,
	input wire logic meas_over,
	input wire logic meas_under,
	input wire logic alarm_led,
	// Settings
	input wire logic first_relay,
	input wire logic second_relay,
	input wire logic [1:0] decimal_position,
	input wire logic remote_write_permit
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic rd;
	logic wr;
	assign rd = acc_valid && acc_func == 8'h03;
	assign wr = acc_valid && acc_func == 8'h06;
	a_done_timing: assert property (acc_valid |=> acc_done) else $error("no answer");
	a_done_cause: assert property (acc_done |-> $past(acc_valid)) else $error("stray answer");
	a_meas_read: assert property (rd && acc_addr == 16'h0001 |=>
		acc_rdata == $past(meas_value) && acc_exc == 8'h00) else $error("bad value read");
	a_cond_over: assert property (rd && acc_addr == 16'h0002 && meas_over |=>
		acc_rdata == 16'h00A0) else $error("bad over status");
	a_cond_under: assert property (rd && acc_addr == 16'h0002 && !meas_over && meas_under
		|=> acc_rdata == 16'h0060) else $error("bad under status");
	a_mirror_read: assert property (rd && (acc_addr == 16'h0003 || acc_addr == 16'h0013)
		|=> acc_rdata == {14'h0, $past(decimal_position)}) else $error("bad point read");
	a_outs_read: assert property (rd && acc_addr == 16'h0004 |=> acc_rdata ==
		{11'h0, $past(alarm_led), 2'h0, $past(second_relay), $past(first_relay)})
		else $error("bad output states");
	a_relay_drive: assert property (wr && remote_write_permit && acc_addr == 16'h0004
		|=> {second_relay, first_relay} == $past(acc_wdata[1:0])) else $error("bad relays");
	a_ident_fixed: assert property (rd && acc_addr == 16'h0021 |=>
		acc_rdata == IDENT_CODE) else $error("bad identification");
	a_bad_func: assert property (acc_valid && !(acc_func inside {8'h03, 8'h06, 8'h10})
		|=> acc_exc == 8'h01) else $error("function not refused");
	a_deny_write: assert property (wr && !remote_write_permit && acc_addr == 16'h0003
		|=> acc_exc == 8'h08 && $stable(decimal_position)) else $error("write not denied");
	a_permit_hold: assert property (wr && acc_addr == 16'h0023 && acc_wdata == 16'h0001
		&& !local_permit_set |=> $stable(remote_write_permit)) else $error("permit set");
	a_range_reject: assert property (wr && remote_write_permit && acc_addr == 16'h0003
		&& acc_wdata > 16'h0003 |=> acc_exc == 8'h03 && $stable(decimal_position))
		else $error("range not refused");
	cover property (wr && !remote_write_permit);
	cover property (rd && meas_over);
	cover property (wr && acc_addr == 16'h0004);
endmodule
bind mmr_bank mmr_bank_properties #(.IDENT_CODE(IDENT_CODE)) i_props (.clk(clk),
	.resetn(resetn), .acc_valid(acc_valid), .acc_func(acc_func), .acc_addr(acc_addr),
	.acc_wdata(acc_wdata), .acc_done(acc_done), .acc_rdata(acc_rdata), .acc_exc(acc_exc),
	.local_permit_set(local_permit_set), .meas_value(meas_value), .meas_over(meas_over),
	.meas_under(meas_under), .alarm_led(alarm_led), .first_relay(first_relay),
	.second_relay(second_relay), .decimal_position(decimal_position),
	.remote_write_permit(remote_write_permit));

// [test/mmr_master_model.sv]
// Model of the protocol engine that hands the bank one register access at a time.
// Assumes the bank answers at the edge that takes the request, in time for the next falling edge.
`timescale 1ns/10ps
module mmr_master_model (
	// Clock
	input wire logic clk,
	// Request
	output logic acc_valid,
	output logic [7:0] acc_func,
	output logic [15:0] acc_addr,
	output logic [15:0] acc_wdata,
	// Answer
	input wire logic acc_done,
	input wire logic [15:0] acc_rdata,
	input wire logic [7:0] acc_exc
);
	initial begin
		acc_valid = 1'b0;
		acc_func = 8'hA5;
		acc_addr = 16'h5AA5;
		acc_wdata = 16'hA55A;
	end
	// Multi-register frames arrive here already split into single accesses
	task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
			output logic dn, output logic [15:0] rd, output logic [7:0] ex);
		@(negedge clk);
		acc_valid = 1'b1;
		acc_func = f;
		acc_addr = a;
		acc_wdata = d;
		@(negedge clk);
		dn = acc_done;
		rd = acc_rdata;
		ex = acc_exc;
		// Idle fields carry inverted data so stale values cannot pass as a request
		acc_valid = 1'b0;
		acc_func = ~f;
		acc_addr = ~a;
		acc_wdata = ~d;
	endtask
endmodule

// [test/tb_top.sv]
// Self-checking bench for the meter register bank.
// Assumes the master model owns the access port; other inputs change at the falling edge.
`timescale 1ns/10ps
module tb_top;
	localparam logic [15:0] ID = 16'h3C5E; // Arbitrary value
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic acc_valid, acc_done, local_permit_set, meas_over, meas_under, alarm_led;
	logic first_relay, second_relay, remote_write_permit;
	logic [7:0] acc_func, acc_exc;
	logic [15:0] acc_addr, acc_wdata, acc_rdata, meas_value, extreme_value;
	logic [1:0] decimal_position;
	logic [3:0] display_intensity;
	logic [15:0] scale_bottom, scale_top;
	logic [2:0] input_span, smoothing_rate, line_rate, reply_extra_wait;
	logic [1:0] curve;
	logic [9:0] under_tolerance;
	logic [7:0] over_tolerance, node_address;
	logic [3:0] menu_lock_flags;
	logic [6:0] link_silence_limit;
	logic glide_entry;
	int bad_count = 0;
	int n_compared = 0;
	logic [15:0] rst [8][2] = '{'{16'h0003, 16'h0000}, '{16'h0010, 16'h0001},
		'{16'h0014, 16'h0000}, '{16'h0015, 16'h03E8}, '{16'h0020, 16'h0001},
		'{16'h0022, 16'h0003}, '{16'h0023, 16'h0001}, '{16'h002D, 16'h0008}};
	// Address, last accepted value, first refused value
	logic [15:0] lim [16][3] = '{'{16'h0010, 16'h0005, 16'h0006},
		'{16'h0011, 16'h0003, 16'h0004}, '{16'h0012, 16'h0005, 16'h0006},
		'{16'h0014, 16'hFC19, 16'hFC18}, '{16'h0015, 16'h270F, 16'h2710},
		'{16'h0016, 16'h03E7, 16'h03E8}, '{16'h0017, 16'h00C7, 16'h00C8},
		'{16'h0022, 16'h0007, 16'h0008}, '{16'h0024, 16'h000F, 16'h0010},
		'{16'h0025, 16'h0005, 16'h0006}, '{16'h0027, 16'h0063, 16'h0064},
		'{16'h002F, 16'h0001, 16'h0002}, '{16'h002D, 16'h0001, 16'h0000},
		'{16'h002D, 16'h0008, 16'h0009}, '{16'h0013, 16'h0003, 16'h0004},
		'{16'h0020, 16'h00C7, 16'h00C8}};
	always #12.5 clk = ~clk;
	mmr_bank #(.IDENT_CODE(ID)) i_dut (.clk(clk), .resetn(resetn), .acc_valid(acc_valid),
		.acc_func(acc_func), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_done(acc_done),
		.acc_rdata(acc_rdata), .acc_exc(acc_exc), .local_permit_set(local_permit_set),
		.meas_value(meas_value), .meas_over(meas_over), .meas_under(meas_under),
		.extreme_value(extreme_value), .alarm_led(alarm_led), .first_relay(first_relay),
		.second_relay(second_relay), .decimal_position(decimal_position),
		.input_span(input_span), .curve(curve), .smoothing_rate(smoothing_rate),
		.scale_bottom(scale_bottom), .scale_top(scale_top), .under_tolerance(under_tolerance),
		.over_tolerance(over_tolerance), .node_address(node_address), .line_rate(line_rate),
		.remote_write_permit(remote_write_permit), .menu_lock_flags(menu_lock_flags),
		.reply_extra_wait(reply_extra_wait), .link_silence_limit(link_silence_limit),
		.display_intensity(display_intensity), .glide_entry(glide_entry));
	mmr_master_model i_master (.clk(clk), .acc_valid(acc_valid), .acc_func(acc_func),
		.acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_done(acc_done),
		.acc_rdata(acc_rdata), .acc_exc(acc_exc));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic acc(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
			input logic [7:0] ex, input logic [15:0] exp_rd);
		logic dn;
		logic [15:0] rd;
		logic [7:0] e;
		i_master.xfer(f, a, d, dn, rd, e);
		check("done", {15'h0000, dn}, 16'h0001);
		check("exception", {8'h00, e}, {8'h00, ex});
		// Writes and refused accesses must answer with zero data
		check("read data", rd, exp_rd);
	endtask
	task automatic w(input logic [15:0] a, input logic [15:0] d, input logic [7:0] ex);
		acc(8'h06, a, d, ex, 16'h0000);
	endtask
	task automatic r(input logic [15:0] a, input logic [15:0] exp);
		acc(8'h03, a, 16'h0000, 8'h00, exp);
	endtask
	task automatic wrap_up;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		local_permit_set = 1'b0;
		meas_over = 1'b0;
		meas_under = 1'b0;
		alarm_led = 1'b0;
		meas_value = 16'hFC19;
		extreme_value = 16'h270F;
		repeat (5) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		foreach (rst[i]) r(rst[i][0], rst[i][1]);
		r(16'h0001, 16'hFC19);
		r(16'h0006, 16'h270F);
		r(16'h0002, 16'h0000);
		meas_under = 1'b1;
		r(16'h0002, 16'h0060);
		meas_over = 1'b1;
		r(16'h0002, 16'h00A0);
		w(16'h0001, 16'h0005, 8'h03);
		w(16'h0021, 16'h0000, 8'h03);
		r(16'h0021, ID);
		acc(8'h03, 16'h0005, 16'h0000, 8'h02, 16'h0000);
		acc(8'h03, 16'h0103, 16'h0000, 8'h02, 16'h0000);
		acc(8'h04, 16'h0003, 16'h0001, 8'h01, 16'h0000);
		acc(8'h10, 16'h0003, 16'h0002, 8'h00, 16'h0000);
		r(16'h0013, 16'h0002);
		w(16'h0013, 16'h0001, 8'h00);
		r(16'h0003, 16'h0001);
		check("point", {14'h0000, decimal_position}, 16'h0001);
		w(16'h0003, 16'h0004, 8'h03);
		w(16'h0004, 16'hFFFE, 8'h00);
		check("relays", {14'h0000, second_relay, first_relay}, 16'h0002);
		r(16'h0004, 16'h0002);
		alarm_led = 1'b1;
		r(16'h0004, 16'h0012);
		foreach (lim[i]) begin
			w(lim[i][0], lim[i][1], 8'h00);
			w(lim[i][0], lim[i][2], 8'h03);
			r(lim[i][0], lim[i][1]);
		end
		check("intensity", {12'h000, display_intensity}, 16'h0008);
		check("span", {13'h0000, input_span}, lim[0][1]);
		check("curve", {14'h0000, curve}, lim[1][1]);
		check("smoothing", {13'h0000, smoothing_rate}, lim[2][1]);
		check("bottom", scale_bottom, lim[3][1]);
		check("top", scale_top, lim[4][1]);
		check("under tolerance", {6'h00, under_tolerance}, lim[5][1]);
		check("over tolerance", {8'h00, over_tolerance}, lim[6][1]);
		check("rate", {13'h0000, line_rate}, lim[7][1]);
		check("locks", {12'h000, menu_lock_flags}, lim[8][1]);
		check("wait", {13'h0000, reply_extra_wait}, lim[9][1]);
		check("silence", {9'h000, link_silence_limit}, lim[10][1]);
		check("entry", {15'h0000, glide_entry}, lim[11][1]);
		check("node", {8'h00, node_address}, lim[15][1]);
		w(16'h0023, 16'h0001, 8'h03);
		w(16'h0023, 16'h0000, 8'h00);
		check("permit", {15'h0000, remote_write_permit}, 16'h0000);
		w(16'h0003, 16'h0002, 8'h08);
		r(16'h0003, 16'h0003);
		w(16'h0023, 16'h0001, 8'h08);
		local_permit_set = 1'b1;
		@(negedge clk);
		local_permit_set = 1'b0;
		check("permit", {15'h0000, remote_write_permit}, 16'h0001);
		w(16'h0003, 16'h0002, 8'h00);
		wrap_up;
	end
	initial begin
		repeat (2000) @(posedge clk);
		bad_count++;
		wrap_up;
	end
endmodule
